// [hw/ife_pkg.sv]
package ife_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFF     = 8'h00;
	localparam logic [7:0] PATTERN_OFF  = 8'h04;
	localparam logic [7:0] BIN_OFF      = 8'h08;
	localparam logic [7:0] ROI_OFF_OFF  = 8'h0C;
	localparam logic [7:0] ROI_SIZE_OFF = 8'h10;
	localparam logic [7:0] MAX_SIZE_OFF = 8'h14;
	localparam logic [7:0] STATUS_OFF   = 8'h18;
	// sensor geometry
	localparam logic [11:0] SENSOR_WIDTH  = 12'h09A8;
	localparam logic [11:0] SENSOR_HEIGHT = 12'h0810;
	// converter depth codes
	typedef enum logic [1:0] {
		DEPTH_10 = 2'b00,
		DEPTH_12 = 2'b01,
		DEPTH_14 = 2'b10
	} adc_depth_t;
	// output pixel width codes
	typedef enum logic [1:0] {
		OUT_8  = 2'b00,
		OUT_10 = 2'b01,
		OUT_12 = 2'b10,
		OUT_16 = 2'b11
	} out_width_t;
	// pattern kinds
	typedef enum logic [1:0] {
		PAT_OFF    = 2'b00,
		PAT_SENSOR = 2'b01,
		PAT_INCR   = 2'b10,
		PAT_VARSEQ = 2'b11
	} pattern_kind_t;
	// mosaic order codes
	typedef enum logic [1:0] {
		MOSAIC_RG = 2'b00,
		MOSAIC_GR = 2'b01,
		MOSAIC_GB = 2'b10,
		MOSAIC_BG = 2'b11
	} mosaic_t;
	// pixel stream beat
	typedef struct packed {
		logic        sof;
		logic        sol;
		logic [15:0] data;
	} pix_t;
	// field layout in CTRL
	localparam int CTRL_REVX  = 0;
	localparam int CTRL_REVY  = 1;
	localparam int CTRL_PROC  = 2;
	localparam int CTRL_ACQ   = 3;
	localparam int CTRL_DEPTH = 4;
	localparam int CTRL_OUTW  = 6;
	localparam int CTRL_COLOR = 8;
	localparam logic [15:0] GREY_SHIFT = 16'h0008;
endpackage

// [hw/image_front_end.sv]
`timescale 1ns/1ps
module image_front_end (
	input  wire logic          mclk,
	input  wire logic          rst_b,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	input  wire logic          sen_valid,
	input  wire logic          sen_sof,
	input  wire logic          sen_sol,
	input  wire logic [13:0]   sen_sample,
	input  wire logic [11:0]   sen_x,
	input  wire logic [11:0]   sen_y,
	output logic               sen_pattern_en,
	output logic               sen_rev_x,
	output logic               sen_rev_y,
	output logic               pix_valid,
	output ife_pkg::pix_t      pix_out,
	output logic               proc_core_enable,
	output ife_pkg::mosaic_t   mosaic_order
);
	// control registers
	logic [9:0]  ctrl_q;
	logic        pattern_source_select_q;
	ife_pkg::pattern_kind_t sen_kind_q;
	ife_pkg::pattern_kind_t pipe_kind_q;
	logic [2:0]  row_combine_factor_q;
	logic [2:0]  column_combine_factor_q;
	logic [11:0] roi_left_offset_q;
	logic [11:0] roi_top_offset_q;
	logic [11:0] roi_width_q;
	logic [11:0] roi_height_q;
	logic [11:0] max_image_width_q;
	logic [11:0] max_image_height_q;
	logic        acq_q;
	logic [7:0]  grey_q;
	logic [7:0]  frame_seq_q;
	logic        wr_hit;
	logic        acq_rise;

	assign wr_hit   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign acq_rise = ctrl_q[ife_pkg::CTRL_ACQ] && !acq_q;

	// bus acknowledge, one cycle after request
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// register writes
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q                  <= 10'h000;
			pattern_source_select_q <= 1'b0;
			sen_kind_q              <= ife_pkg::PAT_OFF;
			pipe_kind_q             <= ife_pkg::PAT_OFF;
			row_combine_factor_q    <= 3'h1;
			column_combine_factor_q <= 3'h1;
			roi_left_offset_q       <= 12'h000;
			roi_top_offset_q        <= 12'h000;
			roi_width_q             <= ife_pkg::SENSOR_WIDTH;
			roi_height_q            <= ife_pkg::SENSOR_HEIGHT;
		end else if (wr_hit && wb_sel_i[0]) begin
			case (wb_adr_i)
				ife_pkg::CTRL_OFF: begin
					ctrl_q[7:0] <= wb_dat_i[7:0];
					// depth held while acquisition stays on
					if (ctrl_q[ife_pkg::CTRL_ACQ] && wb_dat_i[ife_pkg::CTRL_ACQ])
						ctrl_q[5:4] <= ctrl_q[5:4];
					if (wb_sel_i[1])
						ctrl_q[9:8] <= wb_dat_i[9:8];
				end
				ife_pkg::PATTERN_OFF: begin
					pattern_source_select_q <= wb_dat_i[2];
					if (wb_dat_i[2])
						pipe_kind_q <= ife_pkg::pattern_kind_t'(wb_dat_i[1:0]);
					else
						sen_kind_q <= ife_pkg::pattern_kind_t'(wb_dat_i[1:0]);
				end
				ife_pkg::BIN_OFF: begin
					row_combine_factor_q    <= (wb_dat_i[2:0] == 3'h0) ? 3'h1 : wb_dat_i[2:0];
					column_combine_factor_q <= (wb_dat_i[6:4] == 3'h0) ? 3'h1 : wb_dat_i[6:4];
				end
				ife_pkg::ROI_OFF_OFF: begin
					roi_left_offset_q <= wb_dat_i[11:0];
					roi_top_offset_q  <= wb_dat_i[27:16];
				end
				ife_pkg::ROI_SIZE_OFF: begin
					roi_width_q  <= wb_dat_i[11:0];
					roi_height_q <= wb_dat_i[27:16];
				end
				default: begin
				end
			endcase
		end
	end

	// read mux
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			case (wb_adr_i)
				ife_pkg::CTRL_OFF:     wb_dat_o <= {22'h00_0000, ctrl_q};
				ife_pkg::PATTERN_OFF:  wb_dat_o <= {24'h00_0000, pipe_kind_q, sen_kind_q,
					1'b0, pattern_source_select_q,
					(pattern_source_select_q ? pipe_kind_q : sen_kind_q)};
				ife_pkg::BIN_OFF:      wb_dat_o <= {25'h000_0000, column_combine_factor_q,
					1'b0, row_combine_factor_q};
				ife_pkg::ROI_OFF_OFF:  wb_dat_o <= {4'h0, roi_top_offset_q, 4'h0, roi_left_offset_q};
				ife_pkg::ROI_SIZE_OFF: wb_dat_o <= {4'h0, roi_height_q, 4'h0, roi_width_q};
				ife_pkg::MAX_SIZE_OFF: wb_dat_o <= {4'h0, max_image_height_q, 4'h0,
					max_image_width_q};
				ife_pkg::STATUS_OFF:   wb_dat_o <= {14'h0000, mosaic_order, frame_seq_q, grey_q};
				default:               wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// binned maximum size, independent of crop
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			max_image_width_q  <= ife_pkg::SENSOR_WIDTH;
			max_image_height_q <= ife_pkg::SENSOR_HEIGHT;
		end else begin
			max_image_width_q  <= ife_pkg::SENSOR_WIDTH / {9'h000, row_combine_factor_q};
			max_image_height_q <= ife_pkg::SENSOR_HEIGHT / {9'h000, column_combine_factor_q};
		end
	end

	// sensor-side controls: flips happen upstream of crop
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sen_pattern_en   <= 1'b0;
			sen_rev_x        <= 1'b0;
			sen_rev_y        <= 1'b0;
			proc_core_enable <= 1'b0;
			mosaic_order     <= ife_pkg::MOSAIC_RG;
		end else begin
			sen_pattern_en   <= (sen_kind_q == ife_pkg::PAT_SENSOR);
			sen_rev_x        <= ctrl_q[ife_pkg::CTRL_REVX];
			sen_rev_y        <= ctrl_q[ife_pkg::CTRL_REVY];
			proc_core_enable <= ctrl_q[ife_pkg::CTRL_PROC];
			// column phase is bit 0, row phase bit 1
			mosaic_order     <= ctrl_q[ife_pkg::CTRL_COLOR] ? ife_pkg::mosaic_t'({
				ctrl_q[ife_pkg::CTRL_REVY], ctrl_q[ife_pkg::CTRL_REVX]})
				: ife_pkg::MOSAIC_RG;
		end
	end

	// acquisition edge and pattern counters
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acq_q       <= 1'b0;
			grey_q      <= 8'h00;
			frame_seq_q <= 8'h00;
		end else begin
			acq_q <= ctrl_q[ife_pkg::CTRL_ACQ];
			if (acq_rise) begin
				frame_seq_q <= 8'h00;
			end else if (sen_valid && sen_sof) begin
				frame_seq_q <= frame_seq_q + 8'h01;
			end
			if (sen_valid) begin
				grey_q <= sen_sof ? 8'h01 : grey_q + 8'h01;
			end
		end
	end

	// justification, pattern override and crop
	logic [15:0] just_w;
	logic [15:0] pat_w;
	logic [15:0] sel_w;
	logic [15:0] trunc_w;
	logic        in_roi;
	logic [7:0]  cur_grey;
	always_comb begin
		case (ctrl_q[5:4])
			ife_pkg::DEPTH_10: just_w = {sen_sample[9:0], 6'h00};
			ife_pkg::DEPTH_12: just_w = {sen_sample[11:0], 4'h0};
			default:           just_w = {sen_sample[13:0], 2'h0};
		endcase
		cur_grey = sen_sof ? 8'h00 : grey_q;
		case (pipe_kind_q)
			ife_pkg::PAT_INCR:   pat_w = {cur_grey, 8'h00};
			ife_pkg::PAT_VARSEQ: pat_w = {cur_grey ^ frame_seq_q, 8'h00};
			default:             pat_w = 16'h0000;
		endcase
		// pipeline pattern wins; sensor pattern arrives on sen_sample
		sel_w = (pipe_kind_q == ife_pkg::PAT_INCR || pipe_kind_q == ife_pkg::PAT_VARSEQ)
			? pat_w : just_w;
		case (ctrl_q[7:6])
			ife_pkg::OUT_8:  trunc_w = {sel_w[15:8], 8'h00};
			ife_pkg::OUT_10: trunc_w = {sel_w[15:6], 6'h00};
			ife_pkg::OUT_12: trunc_w = {sel_w[15:4], 4'h0};
			default:         trunc_w = sel_w;
		endcase
		// one extra bit so a window reaching the far edge does not wrap
		in_roi = sen_x >= roi_left_offset_q
			&& {1'b0, sen_x} < {1'b0, roi_left_offset_q} + {1'b0, roi_width_q}
			&& sen_y >= roi_top_offset_q
			&& {1'b0, sen_y} < {1'b0, roi_top_offset_q} + {1'b0, roi_height_q};
	end

	// output stage; later stages see pattern data unchanged
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pix_valid <= 1'b0;
			pix_out   <= '0;
		end else begin
			pix_valid    <= sen_valid && in_roi && ctrl_q[ife_pkg::CTRL_ACQ];
			pix_out.data <= trunc_w;
			pix_out.sof  <= sen_x == roi_left_offset_q && sen_y == roi_top_offset_q;
			pix_out.sol  <= sen_x == roi_left_offset_q;
		end
	end

	// output is left-justified with clean padding
	pad_clean_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pix_valid && ctrl_q[7:6] == ife_pkg::OUT_12 |-> pix_out.data[3:0] == 4'h0)
		else $error("low bits not padded");
	depth12_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && pipe_kind_q == ife_pkg::PAT_OFF && ctrl_q[5:4] == ife_pkg::DEPTH_12
		&& ctrl_q[7:6] == ife_pkg::OUT_16 |=> pix_out.data[3:0] == 4'h0)
		else $error("12-bit padding wrong");
	grey_wrap_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && !sen_sof && grey_q == 8'hFF |=> grey_q == 8'h00)
		else $error("grey did not wrap");
	grey_frame_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && sen_sof |=> grey_q == 8'h01)
		else $error("grey not restarted");
	seq_restart_a: assert property (@(posedge mclk) disable iff (!rst_b)
		acq_rise |=> frame_seq_q == 8'h00)
		else $error("sequence not restarted");
	maxw_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$stable(row_combine_factor_q) && row_combine_factor_q == 3'h1 |=>
		max_image_width_q == ife_pkg::SENSOR_WIDTH)
		else $error("max width wrong");
	maxh_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$stable(column_combine_factor_q) && column_combine_factor_q == 3'h1 |=>
		max_image_height_q == ife_pkg::SENSOR_HEIGHT)
		else $error("max height wrong");
	roi_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && sen_x < roi_left_offset_q |=> !pix_valid)
		else $error("pixel outside crop");
	sensor_pat_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_kind_q == ife_pkg::PAT_OFF |=> !sen_pattern_en)
		else $error("sensor pattern stuck on");

	// bus acknowledge lasts one cycle
	ack_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");

	// every request is answered on the next edge
	ack_answer_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged");

	// ten-bit samples pad six low bits
	depth10_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && pipe_kind_q == ife_pkg::PAT_OFF && ctrl_q[5:4] == ife_pkg::DEPTH_10
		&& ctrl_q[7:6] == ife_pkg::OUT_16 |=> pix_out.data[5:0] == 6'h00)
		else $error("10-bit padding wrong");

	// fourteen-bit samples pad two low bits
	depth14_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && pipe_kind_q == ife_pkg::PAT_OFF && ctrl_q[5:4] == ife_pkg::DEPTH_14
		&& ctrl_q[7:6] == ife_pkg::OUT_16 |=> pix_out.data[1:0] == 2'h0)
		else $error("14-bit padding wrong");

	// twelve-bit sample lands in the top twelve bits
	just12_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && pipe_kind_q == ife_pkg::PAT_OFF && ctrl_q[5:4] == ife_pkg::DEPTH_12
		&& ctrl_q[7:6] == ife_pkg::OUT_16 |=> pix_out.data == {$past(sen_sample[11:0]), 4'h0})
		else $error("12-bit sample misplaced");

	// real 14-bit data passes whole at 16-bit output when no pipeline pattern is on
	real_data_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && pipe_kind_q == ife_pkg::PAT_OFF && ctrl_q[5:4] == ife_pkg::DEPTH_14
		&& ctrl_q[7:6] == ife_pkg::OUT_16 |=> pix_out.data == {$past(sen_sample), 2'h0})
		else $error("sensor data altered");

	// eight-bit output clears the low byte
	trunc8_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && ctrl_q[7:6] == ife_pkg::OUT_8 |=> pix_out.data[7:0] == 8'h00)
		else $error("8-bit truncation wrong");

	// ten-bit output clears six low bits
	trunc10_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && ctrl_q[7:6] == ife_pkg::OUT_10 |=> pix_out.data[5:0] == 6'h00)
		else $error("10-bit truncation wrong");

	// increment pattern shows the running grey value
	incr_data_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && !sen_sof && pipe_kind_q == ife_pkg::PAT_INCR
		|=> pix_out.data[15:8] == $past(grey_q))
		else $error("increment value wrong");

	// increment pattern starts each frame at zero
	incr_sof_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && sen_sof && pipe_kind_q == ife_pkg::PAT_INCR
		|=> pix_out.data[15:8] == 8'h00)
		else $error("frame start grey not zero");

	// pipeline pattern hides the sensor pattern
	pipe_wins_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && sen_pattern_en && pipe_kind_q == ife_pkg::PAT_VARSEQ
		|=> pix_out.data[7:0] == 8'h00)
		else $error("sensor pattern leaked");

	// frame sequence steps once per frame start
	seq_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!acq_rise && sen_valid && sen_sof |=> frame_seq_q == $past(frame_seq_q) + 8'h01)
		else $error("frame sequence did not step");

	// nothing leaves while acquisition is stopped
	acq_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!ctrl_q[ife_pkg::CTRL_ACQ] |=> !pix_valid)
		else $error("pixel while stopped");

	// beats right of the window are dropped
	roi_right_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && {1'b0, sen_x} >= {1'b0, roi_left_offset_q} + {1'b0, roi_width_q}
		|=> !pix_valid)
		else $error("pixel right of crop");

	// beats above the window are dropped
	roi_top_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_valid && sen_y < roi_top_offset_q |=> !pix_valid)
		else $error("pixel above crop");

	// frame start marker only on a line start
	sof_line_a: assert property (@(posedge mclk) disable iff (!rst_b)
		pix_valid && pix_out.sof |-> pix_out.sol)
		else $error("frame start off line start");

	// flip requests follow the control bits
	flip_x_a: assert property (@(posedge mclk) disable iff (!rst_b)
		1'b1 |=> sen_rev_x == $past(ctrl_q[ife_pkg::CTRL_REVX]))
		else $error("column flip not passed on");

	flip_y_a: assert property (@(posedge mclk) disable iff (!rst_b)
		1'b1 |=> sen_rev_y == $past(ctrl_q[ife_pkg::CTRL_REVY]))
		else $error("row flip not passed on");

	// column flip alone swaps column phase
	mosaic_col_a: assert property (@(posedge mclk) disable iff (!rst_b)
		ctrl_q[ife_pkg::CTRL_COLOR] && ctrl_q[ife_pkg::CTRL_REVX] && !ctrl_q[ife_pkg::CTRL_REVY]
		|=> mosaic_order == ife_pkg::MOSAIC_GR)
		else $error("column phase wrong");

	// row flip alone swaps row phase
	mosaic_row_a: assert property (@(posedge mclk) disable iff (!rst_b)
		ctrl_q[ife_pkg::CTRL_COLOR] && ctrl_q[ife_pkg::CTRL_REVY] && !ctrl_q[ife_pkg::CTRL_REVX]
		|=> mosaic_order == ife_pkg::MOSAIC_GB)
		else $error("row phase wrong");

	// mono sensors keep the plain order
	mosaic_mono_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!ctrl_q[ife_pkg::CTRL_COLOR] |=> mosaic_order == ife_pkg::MOSAIC_RG)
		else $error("mono order changed");

	// core enable follows its control bit
	core_en_a: assert property (@(posedge mclk) disable iff (!rst_b)
		1'b1 |=> proc_core_enable == $past(ctrl_q[ife_pkg::CTRL_PROC]))
		else $error("core enable wrong");

	// binning factors never read as zero
	bin_h_a: assert property (@(posedge mclk) disable iff (!rst_b)
		row_combine_factor_q != 3'h0)
		else $error("horizontal factor zero");

	bin_v_a: assert property (@(posedge mclk) disable iff (!rst_b)
		column_combine_factor_q != 3'h0)
		else $error("vertical factor zero");

	// depth held while acquisition stays on
	depth_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_hit && wb_sel_i[0] && wb_adr_i == ife_pkg::CTRL_OFF && ctrl_q[ife_pkg::CTRL_ACQ]
		&& wb_dat_i[ife_pkg::CTRL_ACQ] |=> $stable(ctrl_q[5:4]))
		else $error("depth changed while acquiring");

	// sensor pattern request follows its kind
	sensor_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sen_kind_q == ife_pkg::PAT_SENSOR |=> sen_pattern_en)
		else $error("sensor pattern not requested");
endmodule

// [dv/sensor_model.sv]
`timescale 1ns/1ps
// sensor and converter stand-in: one beat per cycle, idle lines scrambled
module sensor_model (
	input  wire logic	mclk,
	input  wire logic	pattern_en,
	input  wire logic	rev_x,
	output logic		valid,
	output logic		sof,
	output logic		sol,
	output logic [13:0]	sample,
	output logic [11:0]	x,
	output logic [11:0]	y
);
	// idle until asked
	initial begin
		valid = 1'b0;
		sof = 1'b0;
		sol = 1'b0;
		sample = 14'h0000;
		x = 12'h000;
		y = 12'h000;
	end
	// one line of n beats; the sensor mirrors columns itself
	task automatic line(input logic [11:0] row, input int n, input logic [13:0] base,
		input logic first);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			valid <= 1'b1;
			sof <= first && (i == 0);
			sol <= (i == 0);
			x <= rev_x ? 12'(n - 1 - i) : 12'(i);
			y <= row;
			sample <= pattern_en ? 14'h0AAA : base + 14'(i);
		end
		@(posedge mclk);
		valid <= 1'b0;
		sample <= ~sample; // stale data must not look valid
		x <= ~x;
	endtask
endmodule

// [dv/image_front_end_tb.sv]
`timescale 1ns/1ps
module image_front_end_tb;
	logic			mclk;
	logic			rst_b;
	logic			cyc;
	logic			stb;
	logic			we;
	logic [7:0]		adr;
	logic [31:0]		dat_w;
	logic [31:0]		dat_r;
	logic			ack;
	logic			s_valid;
	logic			s_sof;
	logic			s_sol;
	logic [13:0]		s_sample;
	logic [11:0]		s_x;
	logic [11:0]		s_y;
	logic			pat_en;
	logic			rev_x;
	logic			rev_y;
	logic			pix_valid;
	ife_pkg::pix_t		pix_out;
	logic			proc_en;
	ife_pkg::mosaic_t	mosaic;
	logic [15:0]		got[$];
	logic [31:0]		rd;
	logic [15:0]		a0;
	int			miscompares;
	int			n_compared;
	logic [1:0]		t_dep[5] = '{2'b00, 2'b01, 2'b10, 2'b01, 2'b10};
	logic [1:0]		t_ow[5] = '{2'b11, 2'b11, 2'b11, 2'b00, 2'b01};
	logic [13:0]		t_smp[5] = '{14'h03FF, 14'h0FFF, 14'h3FFF, 14'h0ABC, 14'h3FFF};
	logic [15:0]		t_exp[5] = '{16'hFFC0, 16'hFFF0, 16'hFFFC, 16'hAB00, 16'hFFC0};

	image_front_end image_front_end_i (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w),
		.wb_dat_o(dat_r), .wb_ack_o(ack), .sen_valid(s_valid), .sen_sof(s_sof),
		.sen_sol(s_sol), .sen_sample(s_sample), .sen_x(s_x), .sen_y(s_y),
		.sen_pattern_en(pat_en), .sen_rev_x(rev_x), .sen_rev_y(rev_y),
		.pix_valid(pix_valid), .pix_out(pix_out), .proc_core_enable(proc_en),
		.mosaic_order(mosaic));
	sensor_model sensor_model_i (.mclk(mclk), .pattern_en(pat_en), .rev_x(rev_x),
		.valid(s_valid), .sof(s_sof), .sol(s_sol), .sample(s_sample), .x(s_x), .y(s_y));

	always #50 mclk = ~mclk;
	// collect every delivered beat
	always @(posedge mclk) if (pix_valid === 1'b1) got.push_back(pix_out.data);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// one line from the sensor, beats gathered afresh
	task automatic px(input logic [11:0] row, input int n, input logic [13:0] base);
		got.delete();
		sensor_model_i.line(row, n, base, 1'b1);
		repeat (2) @(posedge mclk);
	endtask
	// control word: f = {color, proc, revy, revx}
	function automatic logic [31:0] ctl(input logic acq, input logic [1:0] dep,
		input logic [1:0] ow, input logic [3:0] f);
		return {23'h0, f[3], ow, dep, acq, f[2:0]};
	endfunction
	// acquisition stopped, then restarted with the same settings
	task automatic restart(input logic [1:0] dep, input logic [1:0] ow);
		wb(1'b1, ife_pkg::CTRL_OFF, ctl(1'b0, dep, ow, 4'h0));
		wb(1'b1, ife_pkg::CTRL_OFF, ctl(1'b1, dep, ow, 4'h0));
	endtask

	// main sequence
	initial begin
		mclk = 1'b0;
		rst_b = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat_w = 32'h0000_0000;
		miscompares = 0;
		n_compared = 0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		wb(1'b0, ife_pkg::MAX_SIZE_OFF, 32'h0000_0000);
		chk(rd, 32'h0810_09A8);
		wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h1C, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb(1'b1, ife_pkg::BIN_OFF, 32'h0000_0042);
		wb(1'b0, ife_pkg::MAX_SIZE_OFF, 32'h0000_0000);
		chk(rd, {4'h0, ife_pkg::SENSOR_HEIGHT / 12'd4, 4'h0, ife_pkg::SENSOR_WIDTH / 12'd2});
		wb(1'b1, ife_pkg::BIN_OFF, 32'h0000_0011);
		wb(1'b1, ife_pkg::ROI_OFF_OFF, 32'h0001_0002);
		wb(1'b1, ife_pkg::ROI_SIZE_OFF, 32'h0002_0003);
		wb(1'b0, ife_pkg::MAX_SIZE_OFF, 32'h0000_0000);
		chk(rd, 32'h0810_09A8);
		// crop window: columns 2..4 of rows 1..2
		restart(ife_pkg::DEPTH_12, ife_pkg::OUT_16);
		px(12'h001, 6, 14'h0100);
		chk(32'(got.size()), 32'd3);
		for (int i = 0; i < 3; i++) chk(32'(got[i]), 32'h0000_1020 + 32'(16 * i));
		px(12'h000, 6, 14'h0100);
		chk(32'(got.size()), 32'd0);
		wb(1'b1, ife_pkg::ROI_OFF_OFF, 32'h0000_0000);
		wb(1'b1, ife_pkg::ROI_SIZE_OFF, 32'h0810_09A8);
		// converter depths against output widths
		for (int k = 0; k < 5; k++) begin
			restart(t_dep[k], t_ow[k]);
			px(12'h000, 1, t_smp[k]);
			chk(32'(got[0]), 32'(t_exp[k]));
		end
		restart(ife_pkg::DEPTH_12, ife_pkg::OUT_16);
		// pipeline increment across the wrap, then a new frame
		wb(1'b1, ife_pkg::PATTERN_OFF, 32'h0000_0006);
		px(12'h000, 258, 14'h0000);
		for (int i = 0; i < 258; i++) chk(32'(got[i]), {16'h0000, 8'(i), 8'h00});
		px(12'h000, 2, 14'h0000);
		chk({got[0], got[1]}, 32'h0000_0100);
		// sensor source too: pipeline still wins
		wb(1'b1, ife_pkg::PATTERN_OFF, 32'h0000_0001);
		@(posedge mclk);
		chk(32'(pat_en), 32'd1);
		px(12'h000, 1, 14'h0123);
		chk(32'(got[0]), 32'h0000_0000);
		wb(1'b1, ife_pkg::PATTERN_OFF, 32'h0000_0004);
		@(posedge mclk);
		chk(32'(pat_en), 32'd1);
		px(12'h000, 1, 14'h0123);
		chk(32'(got[0]), 32'h0000_AAA0);
		wb(1'b1, ife_pkg::PATTERN_OFF, 32'h0000_0000);
		@(posedge mclk);
		chk(32'(pat_en), 32'd0);
		px(12'h000, 1, 14'h0123);
		chk(32'(got[0]), 32'h0000_1230);
		// variable sequence differs per frame, restarts with acquisition
		wb(1'b1, ife_pkg::PATTERN_OFF, 32'h0000_0007);
		restart(ife_pkg::DEPTH_12, ife_pkg::OUT_16);
		px(12'h000, 1, 14'h0000);
		a0 = got[0];
		px(12'h000, 1, 14'h0000);
		chk(32'(got[0] != a0), 32'd1);
		restart(ife_pkg::DEPTH_12, ife_pkg::OUT_16);
		px(12'h000, 1, 14'h0000);
		chk(32'(got[0]), 32'(a0));
		// flip requests, mosaic order and core enable
		for (int f = 0; f < 4; f++) begin
			wb(1'b1, ife_pkg::CTRL_OFF, ctl(1'b0, 2'b01, 2'b11, {1'b1, f[0], f[1:0]}));
			@(posedge mclk);
			chk(32'({rev_y, rev_x}), 32'(f[1:0]));
			chk(32'(mosaic), 32'(f[1:0]));
			chk(32'(proc_en), 32'(f[0]));
		end
		report_and_stop();
	end
	// watchdog
	initial begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		report_and_stop();
	end
endmodule
